// ===== design/erpf_pkg.sv
// Behaviour
// - primary header starts 000, 0, 1; segmentation 11
// - event packets carry category 7 after APID
// - 14-bit sequence counter per APID and category
// - length field is source bytes plus nine
// - 48-bit timestamp, seconds then fractional seconds
// - secondary header version 010, flags, spare, pad
// - event packets use service type 5
// - event packets use service subtype 3
// - mirror report on failure after recovered failure
// - mirror report first word is 43005
// - mirror second word is unreached position code
// - spectrometer report when busy stays high late
// - spectrometer source data is only 43009
// - acceptance report within four seconds of command
// - acceptance report uses category 1
// - acceptance report uses service type 1
// - acceptance subtype 1 with 32 source bits
// - acceptance source is process id, sequence control
`default_nettype none

// ============================================================
// constants and carriers
package erpf_pkg;
    localparam int CLK_HZ           = 25_000_000;
    localparam int ACCEPT_LIMIT_S   = 4;
    localparam int ACCEPT_LIMIT_CYC = ACCEPT_LIMIT_S * CLK_HZ;

    localparam logic [2:0]  PKT_VERSION = 3'h0;
    localparam logic        PKT_TYPE    = 1'h0;
    localparam logic        DFH_FLAG    = 1'h1;
    localparam logic [1:0]  SEG_FLAGS   = 2'h3;
    localparam logic [3:0]  CAT_EVENT   = 4'h7;
    localparam logic [3:0]  CAT_VERIFY  = 4'h1;
    localparam logic [2:0]  SVC_VERSION = 3'h2;
    localparam logic        CSUM_FLAG   = 1'h0;
    localparam logic [3:0]  SPARE_BITS  = 4'h0;
    localparam logic [7:0]  PAD_BYTE    = 8'h00;
    localparam logic [7:0]  TYPE_EVENT  = 8'h05;
    localparam logic [7:0]  SUB_GROUND  = 8'h03;
    localparam logic [7:0]  TYPE_VERIFY = 8'h01;
    localparam logic [7:0]  SUB_ACCEPT  = 8'h01;
    localparam logic [15:0] EVT_MIRROR  = 16'ha7fd;
    localparam logic [15:0] EVT_SCAN    = 16'ha801;
    localparam logic [15:0] LEN_ADD     = 16'h0009;
    localparam logic [15:0] SRC_MIRROR  = 16'h0004;
    localparam logic [15:0] SRC_SCAN    = 16'h0002;
    localparam logic [15:0] SRC_ACCEPT  = 16'h0004;
    localparam logic [15:0] LEN_EXTRA   = 16'h0007;
    localparam int          PKT_BYTES   = 20;
    localparam int          SEQ_W       = 14;
    localparam int          NUM_CAT     = 2;

    // apb map
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_SCAN    = 8'h04;
    localparam logic [7:0]  REG_STATUS  = 8'h08;
    localparam logic [7:0]  REG_SEQ     = 8'h0c;
    localparam logic        CTRL_RST    = 1'h1;
    localparam logic [31:0] SCAN_RST    = 32'h0000_1000;
    localparam int          ST_DROP     = 4;
    localparam int          ST_LATE     = 5;

    typedef struct packed {
        logic [31:0] seconds;
        logic [15:0] fraction;
    } erpf_time_type;

    typedef struct packed {
        logic [2:0]    version;
        logic          pkt_type;
        logic          dfh_flag;
        logic [6:0]    apid;
        logic [3:0]    category;
        logic [1:0]    segmentation_field;
        logic [13:0]   sequence_counter_field;
        logic [15:0]   length;
        erpf_time_type acquisition_timestamp;
        logic [2:0]    service_version_field;
        logic          checksum_present_flag;
        logic [3:0]    secondary_spare_bits;
        logic [7:0]    service_type_byte;
        logic [7:0]    service_subtype_byte;
        logic [7:0]    header_pad_byte;
        logic [31:0]   source_data_field;
    } erpf_pkt_type;
endpackage

`default_nettype wire

// ===== design/erpf_serializer.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// byte serializer, msb first
module erpf_serializer
    import erpf_pkg::*;
#(
    parameter int BYTES = PKT_BYTES
)
(
    input  wire logic               pclk,      // clock
    input  wire logic               presetn,   // async reset
    input  wire logic               clk_en,    // state freeze when low
    input  wire logic               load,      // take a frame
    input  wire logic [8*BYTES-1:0] frame,     // left aligned frame
    input  wire logic [4:0]         nbytes,    // bytes to send
    input  wire logic               out_ready, // consumer ready
    output logic                    out_valid, // byte valid
    output logic [7:0]              out_data,  // byte
    output logic                    out_last   // last byte of frame
);
    logic [8*BYTES-1:0] shreg;
    logic [4:0]         cnt;

    // load, then shift one byte per accepted beat
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shreg     <= '0;
            cnt       <= 5'h00;
            out_valid <= 1'b0;
            out_last  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (load && !out_valid)
            begin
                shreg     <= frame;
                cnt       <= nbytes;
                out_valid <= 1'b1;
                out_last  <= (nbytes == 5'h01);
            end
            else if (out_valid && out_ready)
            begin
                shreg     <= {shreg[8*BYTES-9:0], 8'h00};
                cnt       <= cnt - 5'h01;
                out_valid <= (cnt != 5'h01);
                out_last  <= (cnt == 5'h02);
            end
        end
    end

    assign out_data = shreg[8*BYTES-1 -: 8];
endmodule

`default_nettype wire

// ===== design/erpf_top.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// event report packet framer
module erpf_top
    import erpf_pkg::*;
#(
    parameter logic [6:0] APP_ID     = 7'h2a,           // arbitrary value
    parameter int         ACCEPT_CYC = ACCEPT_LIMIT_CYC // report deadline
)
(
    input  wire logic          pclk,                       // clock
    input  wire logic          presetn,                    // async reset
    input  wire logic          clk_en,                     // freeze when low
    input  wire logic [7:0]    paddr,                      // apb address
    input  wire logic          psel,                       // apb select
    input  wire logic          penable,                    // apb enable
    input  wire logic          pwrite,                     // apb write
    input  wire logic [31:0]   pwdata,                     // apb write data
    output logic [31:0]        prdata,                     // apb read data
    output logic               pready,                     // apb ready
    output logic               pslverr,                    // apb error
    input  wire logic          mirror_fail,                // positioning failure
    input  wire logic [1:0]    failed_mirror_position,     // 1 space 2 hot 3 cold
    input  wire logic          mirror_recovered,           // failure recovered
    input  wire logic          scan_start,                 // scan begins
    input  wire logic          scan_busy_pin,              // spectrometer busy pin
    input  wire logic          tc_accepted,                // command received ok
    input  wire logic [15:0]   command_process_identifier, // command pid
    input  wire logic [15:0]   command_sequence_control,   // command seq word
    input  wire erpf_time_type acquisition_timestamp,      // on-board time
    input  wire logic          tlm_ready,                  // consumer ready
    output logic               tlm_valid,                  // byte valid
    output logic [7:0]         tlm_data,                   // packet byte
    output logic               tlm_last                    // last packet byte
);
    // ============================================================
    // declarations
    logic            ctrl_en;
    logic [31:0]     scan_limit;
    logic            busy_meta;
    logic            busy_sync;
    logic            recovered;
    logic            mir_pend;
    logic            scan_pend;
    logic            acc_pend;
    logic [15:0]     mir_pos;
    logic [31:0]     acc_src;
    erpf_time_type   mir_time;
    erpf_time_type   scan_time;
    erpf_time_type   acc_time;
    logic [31:0]     scan_cnt;
    logic [31:0]     acc_age;
    logic            dropped;
    logic            late;
    logic [SEQ_W-1:0] seq_cnt [NUM_CAT];
    logic [NUM_CAT-1:0] seq_inc;
    erpf_pkt_type    pkt;

    // ============================================================
    // apb decode
    wire apb_setup  = psel && !penable;
    wire apb_access = psel && penable && pready;
    wire apb_wr     = apb_access && pwrite;
    wire hit_ctrl   = (paddr == REG_CTRL);
    wire hit_scan   = (paddr == REG_SCAN);
    wire hit_status = (paddr == REG_STATUS);
    wire hit_seq    = (paddr == REG_SEQ);
    wire hit_any    = hit_ctrl || hit_scan || hit_status || hit_seq;
    wire ser_busy   = tlm_valid;

    wire [31:0] status_word = {26'h0, late, dropped, ser_busy,
                               acc_pend, scan_pend, mir_pend};
    wire [31:0] seq_word    = {2'h0, seq_cnt[1], 2'h0, seq_cnt[0]};
    wire [31:0] rd_mux      = hit_ctrl   ? {31'h0, ctrl_en} :
                              hit_scan   ? scan_limit :
                              hit_status ? status_word :
                              hit_seq    ? seq_word : 32'h0;

    // zero-wait slave, answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else if (clk_en)
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !hit_any;
            prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // software controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_en    <= CTRL_RST;
            scan_limit <= SCAN_RST;
        end
        else if (clk_en)
        begin
            if (apb_wr && hit_ctrl)
                ctrl_en <= pwdata[0];
            if (apb_wr && hit_scan)
                scan_limit <= pwdata;
        end
    end

    // ============================================================
    // busy pin synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_meta <= 1'b0;
            busy_sync <= 1'b0;
        end
        else if (clk_en)
        begin
            busy_meta <= scan_busy_pin;
            busy_sync <= busy_meta;
        end
    end

    // ============================================================
    // event detection and arbitration
    wire scan_due  = (scan_cnt == 32'h1) && !scan_start;
    wire mir_hit   = ctrl_en && mirror_fail && recovered;
    wire scan_hit  = ctrl_en && scan_due && busy_sync;
    wire acc_hit   = ctrl_en && tc_accepted;
    wire grant_acc = !ser_busy && acc_pend;
    wire grant_mir = !ser_busy && mir_pend && !acc_pend;
    wire grant_scn = !ser_busy && scan_pend && !acc_pend && !mir_pend;
    wire load      = grant_acc || grant_mir || grant_scn;
    wire take_mir  = mir_hit && (!mir_pend || grant_mir);
    wire take_scn  = scan_hit && (!scan_pend || grant_scn);
    wire take_acc  = acc_hit && (!acc_pend || grant_acc);
    wire drop_set  = (mir_hit && !take_mir) || (scan_hit && !take_scn)
                     || (acc_hit && !take_acc);
    wire late_set  = acc_pend && !grant_acc && (acc_age == ACCEPT_CYC - 1);
    wire clr_drop  = apb_wr && hit_status && pwdata[ST_DROP];
    wire clr_late  = apb_wr && hit_status && pwdata[ST_LATE];

    // pending reports and their captured data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            recovered <= 1'b0;
            mir_pend  <= 1'b0;
            scan_pend <= 1'b0;
            acc_pend  <= 1'b0;
            mir_pos   <= 16'h0;
            acc_src   <= 32'h0;
            mir_time  <= '0;
            scan_time <= '0;
            acc_time  <= '0;
            dropped   <= 1'b0;
            late      <= 1'b0;
        end
        else if (clk_en)
        begin
            recovered <= mirror_recovered || (recovered && !mirror_fail);
            mir_pend  <= mir_hit || (mir_pend && !grant_mir);
            scan_pend <= scan_hit || (scan_pend && !grant_scn);
            acc_pend  <= acc_hit || (acc_pend && !grant_acc);
            if (take_mir)
            begin
                mir_pos  <= {14'h0, failed_mirror_position};
                mir_time <= acquisition_timestamp;
            end
            if (take_scn)
                scan_time <= acquisition_timestamp;
            if (take_acc)
            begin
                acc_src  <= {command_process_identifier,
                             command_sequence_control};
                acc_time <= acquisition_timestamp;
            end
            dropped <= drop_set || (dropped && !clr_drop);
            late    <= late_set || (late && !clr_late);
        end
    end

    // scan completion watchdog and report age
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_cnt <= 32'h0;
            acc_age  <= 32'h0;
        end
        else if (clk_en)
        begin
            if (scan_start)
                scan_cnt <= scan_limit;
            else if (scan_cnt != 32'h0)
                scan_cnt <= scan_cnt - 32'h1;
            if (take_acc)
                acc_age <= 32'h0;
            else if (acc_pend && acc_age != ACCEPT_CYC - 1)
                acc_age <= acc_age + 32'h1;
        end
    end

    // ============================================================
    // sequence counters, one per category
    assign seq_inc = {grant_acc, grant_mir || grant_scn};

    generate
        for (genvar g = 0; g < NUM_CAT; g++)
        begin : g_seq
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    seq_cnt[g] <= '0;
                else if (clk_en && seq_inc[g])
                    seq_cnt[g] <= seq_cnt[g] + SEQ_W'(1);
            end
        end
    endgenerate

    // ============================================================
    // packet assembly for the granted report
    wire [3:0]  cat_sel  = acc_pend ? CAT_VERIFY : CAT_EVENT;
    wire [7:0]  type_sel = acc_pend ? TYPE_VERIFY : TYPE_EVENT;
    wire [7:0]  sub_sel  = acc_pend ? SUB_ACCEPT : SUB_GROUND;
    wire [15:0] src_sz   = acc_pend ? SRC_ACCEPT :
                           mir_pend ? SRC_MIRROR : SRC_SCAN;
    wire [15:0] len_sel  = src_sz + LEN_ADD;
    wire [15:0] tot_sel  = len_sel + LEN_EXTRA;
    wire [31:0] src_sel  = acc_pend ? acc_src :
                           mir_pend ? {EVT_MIRROR, mir_pos} :
                           {EVT_SCAN, 16'h0};
    wire erpf_time_type time_sel = acc_pend ? acc_time :
                                   mir_pend ? mir_time : scan_time;
    wire [SEQ_W-1:0] seq_sel = acc_pend ? seq_cnt[1] : seq_cnt[0];

    // header fields in transmit order
    assign pkt = '{
        version:                PKT_VERSION,
        pkt_type:               PKT_TYPE,
        dfh_flag:               DFH_FLAG,
        apid:                   APP_ID,
        category:               cat_sel,
        segmentation_field:     SEG_FLAGS,
        sequence_counter_field: seq_sel,
        length:                 len_sel,
        acquisition_timestamp:  time_sel,
        service_version_field:  SVC_VERSION,
        checksum_present_flag:  CSUM_FLAG,
        secondary_spare_bits:   SPARE_BITS,
        service_type_byte:      type_sel,
        service_subtype_byte:   sub_sel,
        header_pad_byte:        PAD_BYTE,
        source_data_field:      src_sel
    };

    // ============================================================
    // byte stream out
    erpf_serializer #(
        .BYTES     (PKT_BYTES)
    ) u_ser (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .load      (load),
        .frame     (pkt),
        .nbytes    (tot_sel[4:0]),
        .out_ready (tlm_ready),
        .out_valid (tlm_valid),
        .out_data  (tlm_data),
        .out_last  (tlm_last)
    );

    // ============================================================
    // checks
    a_first_byte: assert property (
        @(posedge pclk) disable iff (!presetn)
        load && clk_en |=> tlm_valid
            && tlm_data == {3'h0, 1'h0, 1'h1, APP_ID[6:4]})
        else $error("first header byte wrong");

    a_event_cat: assert property (
        @(posedge pclk) disable iff (!presetn)
        (grant_mir || grant_scn) |-> pkt.category == 4'h7)
        else $error("event category not 7");

    a_seq_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        grant_acc && clk_en |=> seq_cnt[1] == $past(seq_cnt[1]) + 14'h1)
        else $error("verify sequence not incremented");

    a_scan_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        grant_scn |-> pkt.length == 16'h000b && tot_sel == 16'h0012)
        else $error("scan length field wrong");

    a_evt_codes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (grant_mir || grant_scn) |-> pkt.service_type_byte == 8'h05
            && pkt.service_subtype_byte == 8'h03)
        else $error("event service codes wrong");

    a_mirror_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        mir_hit && clk_en |-> (!$past(mirror_fail) || $past(mirror_recovered))
            ##1 mir_pend && mir_pos[15:2] == 14'h0)
        else $error("mirror report without recovery");

    a_scan_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        scan_hit && clk_en |=> scan_pend && scan_cnt == 32'h0)
        else $error("scan report not raised");

    a_acc_fast: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_pend && !ser_busy && clk_en |=> tlm_valid && (!acc_pend || $past(acc_hit))
            && tlm_data[7:5] == 3'h0)
        else $error("accept report not started");

    a_apb_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        apb_setup && clk_en |=> pready && (pslverr == !$past(hit_any)))
        else $error("apb answer missing");
endmodule

`default_nettype wire

// ===== testbench/erpf_tlm_sink.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// telemetry consumer model
module erpf_tlm_sink
(
    input  wire logic       pclk,      // clock
    input  wire logic       presetn,   // async reset
    input  wire logic       slow,      // take a byte every other cycle
    input  wire logic       tlm_valid, // byte valid
    input  wire logic [7:0] tlm_data,  // packet byte
    input  wire logic       tlm_last,  // last byte of packet
    output logic            tlm_ready  // ready for a byte
);
    logic [7:0] rx_q[$];
    int         n_pkt;
    logic       phase;

    // ready every cycle, or every other cycle when stalling
    assign tlm_ready = !slow || phase;

    // collect the byte stream, count whole packets
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= 1'b0;
            n_pkt <= 0;
        end
        else
        begin
            phase <= !phase;
            if (tlm_valid && tlm_ready)
            begin
                rx_q.push_back(tlm_data);
                if (tlm_last)
                    n_pkt <= n_pkt + 1;
            end
        end
    end
endmodule

`default_nettype wire

// ===== testbench/tb_erpf_top.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// testbench
module tb_erpf_top;
    import erpf_pkg::*;
    localparam logic [6:0] APID = 7'h2a; // arbitrary value
    localparam int         ACC  = 50;

    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, tlm_data;
    logic [31:0] pwdata, prdata, r;
    logic mirror_fail, mirror_recovered, scan_start, scan_busy_pin, tc_accepted;
    logic [1:0] failed_mirror_position;
    logic [15:0] command_process_identifier, command_sequence_control;
    erpf_time_type ts;
    logic tlm_ready, tlm_valid, tlm_last, slow, e;
    int mismatches, total_checks, npk;

    always #20 pclk = ~pclk;

    erpf_top #(.APP_ID(APID), .ACCEPT_CYC(ACC)) u_dut (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mirror_fail(mirror_fail), .failed_mirror_position(failed_mirror_position),
        .mirror_recovered(mirror_recovered), .scan_start(scan_start),
        .scan_busy_pin(scan_busy_pin), .tc_accepted(tc_accepted),
        .command_process_identifier(command_process_identifier),
        .command_sequence_control(command_sequence_control),
        .acquisition_timestamp(ts), .tlm_ready(tlm_ready), .tlm_valid(tlm_valid),
        .tlm_data(tlm_data), .tlm_last(tlm_last));

    erpf_tlm_sink u_sink (.pclk(pclk), .presetn(presetn), .slow(slow),
        .tlm_valid(tlm_valid), .tlm_data(tlm_data), .tlm_last(tlm_last),
        .tlm_ready(tlm_ready));

    // ============================================================
    // checking and closing
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // wait until the sink holds npk packets
    task automatic wait_pkt(input int lim);
        int n;
        n = 0;
        while (u_sink.n_pkt != npk && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n < lim, "packet timeout");
        if (n >= lim)
            end_sim();
    endtask

    // compare received bytes with the expected packet image
    task automatic pkt(input logic [3:0] cat, input logic [13:0] sq,
                       input logic [31:0] src, input int ns);
        logic [159:0] x;
        logic [7:0]   ty;
        logic [7:0]   st;
        ty = (cat == 4'h1) ? 8'h01 : 8'h05;
        st = (cat == 4'h1) ? 8'h01 : 8'h03;
        x = {3'h0, 1'h0, 1'h1, APID, cat, 2'h3, sq, 16'(ns + 9), ts,
             3'h2, 1'h0, 4'h0, ty, st, 8'h00, src};
        chk(u_sink.rx_q.size() == ns + 16, "packet size");
        for (int i = 0; i < ns + 16 && i < u_sink.rx_q.size(); i++)
            chk(u_sink.rx_q[i] === x[159 - 8 * i -: 8], $sformatf("byte %0d", i));
        u_sink.rx_q.delete();
    endtask

    // one apb transfer, answer taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk(n < 50, "apb timeout");
        if (n >= 50)
            end_sim();
    endtask

    // ============================================================
    // scenarios
    task automatic s_accept();
        ts <= {32'h0011_6513, 16'hdd8e};
        command_process_identifier <= 16'h0c47;
        command_sequence_control   <= 16'hc001;
        tc_accepted <= 1'b1;
        @(posedge pclk);
        tc_accepted <= 1'b0;
        npk++;
        wait_pkt(ACC);
        pkt(4'h1, 14'h0, 32'h0c47_c001, 4);
        slow <= 1'b1;
        command_sequence_control <= 16'hc002;
        tc_accepted <= 1'b1;
        @(posedge pclk);
        tc_accepted <= 1'b0;
        npk++;
        wait_pkt(200);
        pkt(4'h1, 14'h1, 32'h0c47_c002, 4);
        slow <= 1'b0;
    endtask

    task automatic s_mirror();
        ts <= {32'h0000_0100, 16'h8000};
        mirror_fail <= 1'b1;
        failed_mirror_position <= 2'h2;
        @(posedge pclk);
        mirror_fail <= 1'b0;
        repeat (60) @(posedge pclk);
        chk(u_sink.n_pkt == npk, "report without recovery");
        for (int k = 1; k <= 3; k++)
        begin
            mirror_recovered <= 1'b1;
            @(posedge pclk);
            mirror_recovered <= 1'b0;
            mirror_fail <= 1'b1;
            failed_mirror_position <= 2'(k);
            @(posedge pclk);
            mirror_fail <= 1'b0;
            npk++;
            wait_pkt(200);
            pkt(4'h7, 14'(k - 1), {16'ha7fd, 16'(k)}, 4);
        end
    endtask

    task automatic s_scan();
        apb(1'b1, 8'h04, 32'h0000_000a);
        scan_busy_pin <= 1'b1;
        scan_start <= 1'b1;
        @(posedge pclk);
        scan_start <= 1'b0;
        npk++;
        wait_pkt(200);
        pkt(4'h7, 14'h3, 32'ha801_0000, 2);
        scan_busy_pin <= 1'b0;
        scan_start <= 1'b1;
        @(posedge pclk);
        scan_start <= 1'b0;
        repeat (40) @(posedge pclk);
        chk(u_sink.n_pkt == npk, "report with busy low");
    endtask

    task automatic s_regs();
        apb(1'b0, 8'h0c, 32'h0);
        chk(r === {2'h0, 14'h2, 2'h0, 14'h4} && e === 1'b0, "sequence counters");
        apb(1'b0, 8'h40, 32'h0);
        chk(r === 32'h0 && e === 1'b1, "unmapped read");
    endtask

    // disabled events, dropped report, status read and clear
    task automatic s_status();
        apb(1'b1, 8'h00, 32'h0);
        tc_accepted <= 1'b1;
        @(posedge pclk);
        tc_accepted <= 1'b0;
        repeat (30) @(posedge pclk);
        chk(u_sink.n_pkt == npk, "report while disabled");
        apb(1'b1, 8'h00, 32'h1);
        tc_accepted <= 1'b1;
        repeat (3) @(posedge pclk);
        tc_accepted <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        chk(r === 32'h0000_001c && e === 1'b0, "status after drop");
        npk += 2;
        wait_pkt(200);
        chk(u_sink.rx_q.size() == 40, "two accept reports");
        u_sink.rx_q.delete();
        apb(1'b1, 8'h08, 32'h0000_0010);
        apb(1'b0, 8'h08, 32'h0);
        chk(r === 32'h0, "status not cleared");
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {mirror_fail, mirror_recovered, scan_start, scan_busy_pin, tc_accepted} = '0;
        {failed_mirror_position, command_process_identifier, command_sequence_control} = '0;
        ts = '0;
        clk_en = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_accept();
        s_mirror();
        s_scan();
        s_regs();
        s_status();
        end_sim();
    end
endmodule

`default_nettype wire
